// ===== dv/controller_model.sv
`timescale 1ns/1ps
module controller_model (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  // requests from the bench
  input  wire logic level_go_in,
  input  wire logic term_go_in,
  input  wire logic sample_in,
  // pins toward the device
  output logic      leveling_mode_out,
  output logic      strobe_rise_out,
  output logic      clock_sample_out,
  output logic      term_control_out
);
  logic [5:0] lvl_cnt;
  logic [2:0] term_cnt;

  // one down-counter per pending wait, counted in real edges
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      leveling_mode_out <= 1'h0;
      strobe_rise_out   <= 1'h0;
      clock_sample_out  <= 1'h0;
      term_control_out  <= 1'h0;
      lvl_cnt           <= 6'h28;
      term_cnt          <= 3'h0;
    end else begin
      leveling_mode_out <= level_go_in;
      strobe_rise_out   <= leveling_mode_out && lvl_cnt == 6'h01;
      // no strobe until 40 edges after leveling entry
      if (!leveling_mode_out) begin
        lvl_cnt <= 6'h28;
      end else if (lvl_cnt == 6'h01) begin
        lvl_cnt          <= 6'h04;
        clock_sample_out <= sample_in;
      end else begin
        lvl_cnt <= lvl_cnt - 6'h01;
      end
      // always hold the long figure, which covers the short one
      if (term_cnt != 3'h0) begin
        term_cnt <= term_cnt - 3'h1;
      end else if (term_go_in) begin
        term_cnt <= 3'h6;
      end
      term_control_out <= (term_go_in && term_cnt == 3'h0) ||
                          term_cnt > 3'h1;
    end
  end
endmodule : controller_model

// ===== dv/dram_command_timing_guard_tb.sv
`timescale 1ns/1ps
module dram_command_timing_guard_tb;
  import timing_guard_pkg::*;
  logic       clk_sys_in, arst_n_in, write_cmd_in, chop_fixed_in;
  logic [3:0] write_latency_in;
  logic       cal_short_cmd_in, clock_enable_in, row_op_busy_in;
  logic       loop_frozen_in, level_go, term_go, sample;
  logic       leveling_mode_in, strobe_rise_in, clock_sample_in;
  logic       term_control_in, write_start_out, cal_busy_out;
  logic       powerdown_out, term_enable_out, leveling_data_out;
  logic [2:0] th, ph, vh, sh;
  int         error_cnt, samples_checked, cycles, seed;

  dram_command_timing_guard dut (.*);
  controller_model partner (.clk_sys_in, .arst_n_in, .level_go_in(level_go),
    .term_go_in(term_go), .sample_in(sample),
    .leveling_mode_out(leveling_mode_in), .strobe_rise_out(strobe_rise_in),
    .clock_sample_out(clock_sample_in), .term_control_out(term_control_in));

  initial begin
    clk_sys_in = 1'h0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  task final_report;
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // edges from command to start pulse
  function automatic logic [15:0] write_delay(logic [3:0] wl, logic chop);
    return 16'(wl) + 16'(chop ? WRITE_START_CHOP_MRS : WRITE_START_LONG) + 1;
  endfunction : write_delay

  task do_write(input logic [3:0] wl, input logic chop, input bit dup);
    int k;
    int hits;
    hits = 0;
    @(posedge clk_sys_in);
    write_cmd_in     <= 1'h1;
    write_latency_in <= wl;
    chop_fixed_in    <= chop;
    // a second command while counting must be dropped
    for (k = 1; k <= 2 * write_delay(wl, chop) + 2; k++) begin
      @(posedge clk_sys_in);
      write_cmd_in <= dup && k == 2 && write_delay(wl, chop) > 4;
      #1;
      if (write_start_out === 1'h1) begin
        if (hits == 0) chk(16'(k), write_delay(wl, chop));
        hits++;
      end
    end
    chk(16'(hits), 16'h1);
  endtask : do_write

  task do_cal;
    int hits;
    hits = 0;
    @(posedge clk_sys_in);
    cal_short_cmd_in <= 1'h1;
    @(posedge clk_sys_in);
    cal_short_cmd_in <= 1'h0;
    #1;
    if (cal_busy_out === 1'h1) hits++;
    repeat (79) begin
      @(posedge clk_sys_in);
      #1;
      if (cal_busy_out === 1'h1) hits++;
    end
    chk(16'(hits), 16'(CAL_SHORT_CYCLES));
  endtask : do_cal

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      final_report();
    end
    if (arst_n_in) begin
      // new row work and a clock-enable change never share an edge,
      // so clock-enable drops at least a cycle after a refresh
      if ((($random(seed)) & 3) == 0) begin
        row_op_busy_in  <= 1'($random(seed));
        // writes go on while frozen, only reads and synchronous termination need the lock
        loop_frozen_in  <= 1'($random(seed));
      end else if ((($random(seed)) & 3) == 0) begin
        clock_enable_in <= 1'($random(seed));
      end
      term_go <= (($random(seed)) & 15) == 0;
      sample  <= 1'($random(seed));
    end
  end

  // term and power-down outputs follow inputs that stood for two cycles; feedback matches the sample at strobe rise
  always @(posedge clk_sys_in) begin
    #1;
    th = {th[1:0], term_control_in};
    ph = {ph[1:0], !clock_enable_in && !row_op_busy_in};
    vh = {vh[1:0], strobe_rise_in};
    sh = {sh[1:0], clock_sample_in};
    if (arst_n_in && cycles > 6) begin
      if (th[2] == th[1]) chk(16'(term_enable_out), 16'(th[1]));
      if (ph[2] == ph[1]) chk(16'(powerdown_out), 16'(ph[1]));
      if (vh[2]) chk(16'(leveling_data_out), 16'(sh[2]));
    end
  end

  initial begin
    seed = 63;
    {arst_n_in, write_cmd_in, chop_fixed_in, cal_short_cmd_in} = 4'h0;
    {clock_enable_in, row_op_busy_in, loop_frozen_in} = 3'h0;
    {level_go, term_go, sample} = 3'h0;
    write_latency_in = 4'h0;
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    level_go  <= 1'h1;
    do_write(4'h0, 1'h1, 1'b0);
    do_write(4'hf, 1'h0, 1'b1);
    do_write(4'h5, 1'h0, 1'b1);
    do_write(4'h5, 1'h1, 1'b0);
    repeat (20) do_write(4'($random(seed)), 1'($random(seed)), 1'b1);
    do_cal();
    do_cal();
    final_report();
  end
endmodule : dram_command_timing_guard_tb

// ===== rtl/delay_count_if.sv
`timescale 1ns/1ps
interface delay_count_if;
  import timing_guard_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             busy;
  logic             done;
  modport owner (output load, output value, input busy, input done);
  modport timer (input load, input value, output busy, output done);
endinterface : delay_count_if

// ===== rtl/delay_counter.sv
`timescale 1ns/1ps
module delay_counter
  import timing_guard_pkg::*;
(
  input wire logic  clk_sys_in,
  input wire logic  arst_n_in,
  delay_count_if.timer port
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             done_q;
  logic             next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (port.load) begin
      next_count = port.value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done  = (count == CNT_W'(1));
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count  <= '0;
      done_q <= 1'b0;
    end else begin
      count  <= next_count;
      done_q <= next_done;
    end
  end

  assign port.busy = (count != '0);
  assign port.done = done_q;
endmodule : delay_counter

// ===== rtl/dram_command_timing_guard.sv
`timescale 1ns/1ps
// Summary of operation
// R1: controller holds termination high 4 cycles alone or with chop-four write; the controller model always holds 6.
// R2: controller holds termination high 6 cycles with burst-eight write.
// R3: in frozen-loop power-down, termination follows control within 2-8.5 ns.
// R4: controller waits 40 cycles after leveling entry before first strobe rise.
// R5: controller waits 25 cycles after leveling entry before driving strobes.
// R6: leveling feedback appears on data within 7.5 or 9 ns of strobe rise.
// R7: cycle constraints count real clock edges, not elapsed time.
// R8: after a timing violation the controller resets and reinitialises.
// R9: nanosecond figures become cycle counts, rounded up; leveling feedback latency rounds down.
// R10: write-to-power-down uses write recovery over period, rounded up; powerdown_out here ignores writes.
// R11: internal write starts 4 cycles after latency, 2 for fixed chop four.
// R12: power-down takes effect only after pending row operations complete.
// R13: refresh-to-power-down may need the exit-to-locked-loop delay too.
// R14: short calibration corrects its step within 64 cycles.
// R15: only reads and synchronous termination need the locked loop.
// R16: at most eight refreshes postponed; gap below nine intervals.
// R17: controller waits 1 cycle after refresh before clock-enable low.
// R18: controller keeps one down-counter per pending constraint.
module dram_command_timing_guard
  import timing_guard_pkg::*;
#(
  parameter bit SLOW_GRADE = 1'b0
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             arst_n_in,
  // command inputs, already on clk_sys_in
  input  wire logic             write_cmd_in,
  input  wire logic [3:0]       write_latency_in,
  input  wire logic             chop_fixed_in,
  input  wire logic             cal_short_cmd_in,
  input  wire logic             leveling_mode_in,
  input  wire logic             strobe_rise_in,
  input  wire logic             clock_enable_in,
  input  wire logic             row_op_busy_in,
  input  wire logic             loop_frozen_in,
  input  wire logic             term_control_in,
  input  wire logic             clock_sample_in,
  // status outputs
  output logic                  write_start_out,
  output logic                  cal_busy_out,
  output logic                  powerdown_out,
  output logic                  term_enable_out,
  output logic                  leveling_data_out
);
  import timing_guard_pkg::*;

  localparam logic [CNT_W-1:0] FB_CYC = SLOW_GRADE ?
    CNT_W'(LEVEL_FB_SLOW_CYC) : CNT_W'(LEVEL_FB_FAST_CYC);

  delay_count_if cal_if ();
  delay_counter u_cal (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .port       (cal_if.timer)
  );

  op_state_type     wr_state;
  op_state_type     next_wr_state;
  logic [CNT_W-1:0] wr_count;
  logic [CNT_W-1:0] next_wr_count;
  logic             next_write_start;
  logic             next_powerdown;
  logic [CNT_W-1:0] term_count;
  logic [CNT_W-1:0] next_term_count;
  logic             next_term_enable;
  logic [CNT_W-1:0] fb_count;
  logic [CNT_W-1:0] next_fb_count;
  logic             next_leveling_data;
  logic             fb_sample;
  logic             next_fb_sample;

  assign cal_if.load  = cal_short_cmd_in;                       // see R14
  assign cal_if.value = CNT_W'(CAL_SHORT_CYCLES);
  assign cal_busy_out = cal_if.busy;

  // edge counting, not time: jitter cannot shorten a count (see R7)
  always_comb begin
    next_wr_state    = wr_state;
    next_wr_count    = wr_count;
    next_write_start = 1'b0;
    case (wr_state)
      OP_IDLE: begin
        if (write_cmd_in) begin
          next_wr_count = CNT_W'(write_latency_in) + (chop_fixed_in ?
            CNT_W'(WRITE_START_CHOP_MRS) : CNT_W'(WRITE_START_LONG));
          next_wr_state = OP_WAIT;                              // see R11
        end
      end
      OP_WAIT: begin
        next_wr_count = wr_count - 1'b1;
        if (wr_count == CNT_W'(1)) begin
          next_write_start = 1'b1;                              // see R11
          next_wr_state    = OP_IDLE;
        end
      end
      default: next_wr_state = OP_IDLE;
    endcase
  end

  // power-down waits for row operations in flight
  always_comb begin
    next_powerdown = !clock_enable_in && !row_op_busy_in;       // see R12
  end

  // asynchronous termination modelled by cycle delay of the request
  always_comb begin
    next_term_count  = term_count;
    next_term_enable = term_enable_out;
    if (!loop_frozen_in) begin
      next_term_count  = '0;
      next_term_enable = term_control_in;
    end else if (term_control_in != term_enable_out) begin
      if (term_count >= CNT_W'(ASYNC_TERM_CYCLES - 1)) begin // see R9
        next_term_enable = term_control_in;                     // see R3
        next_term_count  = '0;
      end else begin
        next_term_count = term_count + 1'b1;
      end
    end else begin
      next_term_count = '0;
    end
  end

  // capture clock at strobe rise, present after feedback latency;
  // a later clock value must not leak into the reported sample
  always_comb begin
    next_fb_count      = fb_count;
    next_fb_sample     = fb_sample;
    next_leveling_data = leveling_data_out;
    if (!leveling_mode_in) begin
      next_fb_count      = '0;
      next_fb_sample     = 1'b0;
      next_leveling_data = 1'b0;
    end else if (strobe_rise_in) begin
      next_fb_count  = FB_CYC;                                  // see R6
      next_fb_sample = clock_sample_in;                         // see R6
    end else if (fb_count != '0) begin
      next_fb_count = fb_count - 1'b1;
      if (fb_count == CNT_W'(1)) begin
        next_leveling_data = fb_sample;                         // see R6
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_state          <= OP_IDLE;
      wr_count          <= '0;
      write_start_out   <= 1'b0;
      powerdown_out     <= 1'b0;
      term_count        <= '0;
      term_enable_out   <= 1'b0;
      fb_count          <= '0;
      fb_sample         <= 1'b0;
      leveling_data_out <= 1'b0;
    end else begin
      wr_state          <= next_wr_state;
      wr_count          <= next_wr_count;
      write_start_out   <= next_write_start;
      powerdown_out     <= next_powerdown;
      term_count        <= next_term_count;
      term_enable_out   <= next_term_enable;
      fb_count          <= next_fb_count;
      fb_sample         <= next_fb_sample;
      leveling_data_out <= next_leveling_data;
    end
  end

  write_start_a : assert property ( // see R11
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_state == OP_IDLE && write_cmd_in && !chop_fixed_in &&
     write_latency_in == 4'h5) |-> ##10 write_start_out)
    else $error("internal write start late or early");

  write_chop_a : assert property ( // see R11
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_state == OP_IDLE && write_cmd_in && chop_fixed_in &&
     write_latency_in == 4'h5) |=> !write_start_out[*7] ##1 write_start_out)
    else $error("chop four write start wrong");

  cal_window_a : assert property ( // see R14
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(cal_if.load) |=> cal_busy_out[*8] ##57 !cal_busy_out)
    else $error("calibration window not 64 cycles");

  powerdown_hold_a : assert property ( // see R12
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    row_op_busy_in |=> !powerdown_out)
    else $error("power-down before row work finished");

  term_async_a : assert property ( // see R3
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (loop_frozen_in && $changed(term_control_in)) |->
      term_enable_out != term_control_in)
    else $error("termination switched faster than 2 ns");

  leveling_off_a : assert property ( // see R6
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !leveling_mode_in |=> !leveling_data_out)
    else $error("feedback driven outside leveling");

  leveling_latency_a : assert property ( // see R6
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (leveling_mode_in && fb_count == CNT_W'(1) && !strobe_rise_in) |=>
      leveling_data_out == $past(fb_sample))
    else $error("leveling feedback not presented on time");

  term_follow_a : assert property ( // see R3
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !loop_frozen_in |=> term_enable_out == $past(term_control_in))
    else $error("termination not following control");

  powerdown_entry_a : assert property ( // see R12
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!clock_enable_in && !row_op_busy_in) |=> powerdown_out)
    else $error("power-down not entered when idle");

  write_single_a : assert property ( // see R11
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    write_start_out |=> !write_start_out)
    else $error("internal write start longer than one cycle");
endmodule : dram_command_timing_guard

// ===== rtl/timing_guard_pkg.sv
package timing_guard_pkg;
  localparam int unsigned CLK_PERIOD_PS        = 25000;
  // asynchronous termination switch window, in ps
  localparam int unsigned ASYNC_TERM_MIN_PS    = 2000;
  localparam int unsigned ASYNC_TERM_MAX_PS    = 8500;
  // leveling feedback latency per grade, in ps
  localparam int unsigned LEVEL_FB_FAST_PS     = 7500;
  localparam int unsigned LEVEL_FB_SLOW_PS     = 9000;
  localparam int unsigned CAL_SHORT_CYCLES     = 64;
  localparam int unsigned WRITE_START_LONG     = 4;
  localparam int unsigned WRITE_START_CHOP_MRS = 2;
  localparam int unsigned CNT_W                = 8;

  // least time rounds up, never below one cycle
  function automatic int unsigned cycles_up(input int unsigned ps);
    int unsigned n;
    n = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction : cycles_up

  // longest time rounds down, never below one cycle
  function automatic int unsigned cycles_down(input int unsigned ps);
    int unsigned n;
    n = ps / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction : cycles_down

  localparam int unsigned ASYNC_TERM_CYCLES = cycles_up(ASYNC_TERM_MIN_PS);
  localparam int unsigned LEVEL_FB_FAST_CYC = cycles_down(LEVEL_FB_FAST_PS);
  localparam int unsigned LEVEL_FB_SLOW_CYC = cycles_down(LEVEL_FB_SLOW_PS);

  typedef enum logic [1:0] {
    OP_IDLE, OP_WAIT, OP_RUN
  } op_state_type;
endpackage : timing_guard_pkg
